// ---- hw/mps_pkg.sv ----
// Purpose: shared constants for the management-point supervision block
// Assumes: byte addresses on a 32-bit AXI4-Lite bus
// Notes: second-based counts are in one-second ticks, not clock cycles
package mps_pkg;
  // --------------------------------------------------------------
  // Register byte offsets
  // --------------------------------------------------------------
  localparam logic [7:0] SUP_PPI_ADDR = 8'h00;
  localparam logic [7:0] SUP_PPT_ADDR = 8'h04;
  localparam logic [7:0] SUP_PATH_MULTIPLEX_ENTITY_ADDR = 8'h08;
  localparam logic [7:0] SUP_TSI_ADDR = 8'h0c;
  localparam logic [7:0] SUP_SCA_ADDR = 8'h10;
  localparam logic [7:0] SUP_VPE_ADDR = 8'h14;
  localparam logic [7:0] MUX_CFG_ADDR = 8'h18;
  localparam logic [7:0] VPI_ADDR = 8'h1c;
  localparam logic [7:0] PKT_FMT_ADDR = 8'h20;
  localparam logic [7:0] PKT_RATE_ADDR = 8'h24;
  localparam logic [7:0] FAIL_ADDR = 8'h28;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h2c;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h30;
  localparam logic [7:0] TIME_ADDR = 8'h34;
  localparam logic [7:0] FAIL_TIME_ADDR = 8'h38;
  localparam logic [7:0] PERIOD_TIME_ADDR = 8'h3c;
  localparam logic [7:0] CUR_BASE_ADDR = 8'h40;
  localparam logic [7:0] REC_BASE_ADDR = 8'h58;
  // --------------------------------------------------------------
  // Fields and reset values
  // --------------------------------------------------------------
  localparam int MUX_DISCARD_BIT = 0;
  localparam int MUX_HEC_BIT = 1;
  localparam logic SUP_RST = 1'b1;
  localparam logic DISCARD_RST = 1'b1;
  localparam logic HEC_RST = 1'b1;
  localparam logic FMT204_RST = 1'b0;
  // Failure and interrupt vector layout
  localparam int NFAIL = 14;
  localparam int F_PPI_LOS = 0;
  localparam int F_PDH_LAST = 6;
  localparam int F_TS_FIRST = 7;
  localparam int F_TS_LAST = 12;
  localparam int F_HW = 13;
  localparam int IRQ_W = 16;
  localparam int IRQ_PERIOD_BIT = 14;
  localparam int IRQ_DAY_BIT = 15;
  // Performance counters: NES NSES NBBE FES FSES FBBE
  localparam int NEV = 6;
  localparam int EBC_W = 16;
  localparam int CNT_W = 16;
  // --------------------------------------------------------------
  // Timing in one-second ticks; bus response codes
  // --------------------------------------------------------------
  localparam int QUARTER_SECS = 900;
  localparam int DAY_SECS = 86400;
  localparam logic [3:0] SET_SECS = 4'h3;
  localparam logic [3:0] CLR_SECS = 4'ha;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- hw/mps_sec_if.sv ----
// Purpose: per-second primitives and counters between top and events
// Assumes: single clock domain
// Notes: none
`timescale 1ns/10ps
`default_nettype none
interface mps_sec_if;
  import mps_pkg::*;
  logic sec_valid;
  logic period_end;
  logic [EBC_W-1:0] nebc;
  logic [EBC_W-1:0] febc;
  logic nds;
  logic fds;
  logic [CNT_W-1:0] cur [NEV];
  logic [CNT_W-1:0] rec [NEV];
  modport src (output sec_valid, period_end, nebc, febc, nds, fds,
               input cur, rec);
  modport perf (input sec_valid, period_end, nebc, febc, nds, fds,
                output cur, rec);
endinterface
`default_nettype wire

// ---- hw/mps_perf_event.sv ----
// Purpose: derive ES, SES, BBE per second and count them per period
// Assumes: primitives valid for one cycle per second
// Notes: counters saturate instead of wrapping
`timescale 1ns/10ps
`default_nettype none
module mps_perf_event
  import mps_pkg::*;
#(
  parameter logic [EBC_W-1:0] SES_THRESH = 16'h0960
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Per-second link
  mps_sec_if.perf sec
);
  logic nses, fses, nes, fes;
  logic [CNT_W-1:0] inc [NEV];

  function automatic logic [CNT_W-1:0] sat_add(
      input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
    logic [CNT_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[CNT_W] ? {CNT_W{1'b1}} : s[CNT_W-1:0];
  endfunction

  always_comb begin
    nses = sec.nds || (sec.nebc >= SES_THRESH);
    nes = sec.nds || (sec.nebc != '0);
    fses = !sec.nds && (sec.fds || (sec.febc >= SES_THRESH));
    fes = !sec.nds && (sec.fds || (sec.febc != '0));
    inc[0] = {{(CNT_W-1){1'b0}}, sec.sec_valid & nes};
    inc[1] = {{(CNT_W-1){1'b0}}, sec.sec_valid & nses};
    inc[2] = (sec.sec_valid && !nses) ? sec.nebc : '0;
    inc[3] = {{(CNT_W-1){1'b0}}, sec.sec_valid & fes};
    inc[4] = {{(CNT_W-1){1'b0}}, sec.sec_valid & fses};
    inc[5] = (sec.sec_valid && !fses && !sec.nds) ? sec.febc : '0;
  end

  // Closing second is folded into the recent copy, never lost
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NEV; i++) begin
        sec.cur[i] <= '0;
        sec.rec[i] <= '0;
      end
    end else if (ce_in) begin
      for (int i = 0; i < NEV; i++) begin
        if (sec.period_end) begin
          sec.rec[i] <= sat_add(sec.cur[i], inc[i]);
          sec.cur[i] <= '0;
        end else begin
          sec.cur[i] <= sat_add(sec.cur[i], inc[i]);
        end
      end
    end
  end
endmodule // mps_perf_event
`default_nettype wire

// ---- hw/mps_top.sv ----
// Purpose: management-point supervision, filtering and configuration
// Assumes: tick_1s_in from the local real-time clock, asynchronous
// Notes: AXI4-Lite slave; one write and one read in flight at most
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module mps_top
  import mps_pkg::*;
#(
  parameter int VPI_W = 12,
  parameter logic [EBC_W-1:0] SES_THRESH = 16'h0960,
  parameter int QUARTER_TICKS = QUARTER_SECS,
  parameter int DAY_TICKS = DAY_SECS
) (
  // Clock, reset, enable
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Real-time clock
  input wire logic tick_1s_in,
  // Defects from basic functions, same clock
  input wire logic signal_absent_fail_in,
  input wire logic alarm_indication_fail_in,
  input wire logic frame_loss_fail_in,
  input wire logic remote_alarm_fail_in,
  input wire logic remote_error_fail_in,
  input wire logic remote_defect_fail_in,
  input wire logic cell_delineation_loss_in,
  input wire logic status_fail_in,
  input wire logic sn_indication_fail_in,
  input wire logic lost_mpeg_cell_fail_in,
  input wire logic ts_signal_absent_fail_in,
  input wire logic ts_input_length_fail_in,
  input wire logic ts_output_length_fail_in,
  input wire logic hw_transfer_fail_in,
  // Per-second primitives and per-cycle packet pass, same clock
  input wire logic [EBC_W-1:0] near_errored_block_count_in,
  input wire logic [EBC_W-1:0] far_errored_block_count_in,
  input wire logic near_defect_second_in,
  input wire logic far_defect_second_in,
  input wire logic packet_pass_in,
  // Provisioning to basic functions, interrupt to the manager
  output logic pdh_monitored_out,
  output logic ts_monitored_out,
  output logic cell_discard_out,
  output logic hec_correct_out,
  output logic [VPI_W-1:0] vpi_out,
  output logic pkt_format_204_out,
  output logic irq_out,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } mps_wr_state_t;

  mps_wr_state_t wr_state_q;
  mps_sec_if sec ();

  logic tick_s1_q, tick_s2_q, tick_s3_q, tick_lvl_q;
  logic sec_pulse;
  logic [31:0] time_q, fail_time_q, period_time_q;
  logic [16:0] quarter_q, day_q;
  logic quarter_end, day_end;
  logic [NFAIL-1:0] raw_fail, fail_q;
  logic [3:0] persist_q [NFAIL];
  logic [IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_set;
  logic [31:0] pkt_cnt_q, pkt_rate_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_have_q, w_have_q, do_write, wr_hit;
  logic [31:0] wd;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [2:0] cur_idx, rec_idx;

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  function automatic logic [2:0] word_idx(input logic [7:0] a,
      input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    word_idx = d[4:2];
  endfunction

  // --------------------------------------------------------------
  // One-second tick and local time
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_s1_q <= 1'b0;
      tick_s2_q <= 1'b0;
      tick_s3_q <= 1'b0;
      tick_lvl_q <= 1'b0;
    end else if (ce_in) begin
      tick_s1_q <= tick_1s_in;
      tick_s2_q <= tick_s1_q;
      tick_s3_q <= tick_s2_q;
      if (tick_s2_q == tick_s3_q) begin
        tick_lvl_q <= tick_s3_q;
      end
    end
  end

  assign sec_pulse = tick_s2_q && tick_s3_q && !tick_lvl_q;
  assign quarter_end = sec_pulse && (quarter_q == 17'(QUARTER_TICKS - 1));
  assign day_end = sec_pulse && (day_q == 17'(DAY_TICKS - 1));

  // Writing the time restarts both periods on that second
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      time_q <= '0;
      quarter_q <= '0;
      day_q <= '0;
    end else if (ce_in) begin
      if (do_write && aw_addr_q == TIME_ADDR) begin
        time_q <= merge(time_q, w_data_q, w_strb_q);
        quarter_q <= '0;
        day_q <= '0;
      end else if (sec_pulse) begin
        time_q <= time_q + 32'h1;
        quarter_q <= quarter_end ? '0 : quarter_q + 17'h1;
        day_q <= day_end ? '0 : day_q + 17'h1;
      end
    end
  end

  // --------------------------------------------------------------
  // Fault cause persistency filter
  // --------------------------------------------------------------
  // Unmonitored functions report nothing; hardware always reports
  always_comb begin
    raw_fail = {hw_transfer_fail_in,
                ts_output_length_fail_in, ts_input_length_fail_in,
                ts_signal_absent_fail_in, lost_mpeg_cell_fail_in,
                sn_indication_fail_in, status_fail_in,
                cell_delineation_loss_in, remote_defect_fail_in,
                remote_error_fail_in, remote_alarm_fail_in,
                frame_loss_fail_in, alarm_indication_fail_in,
                signal_absent_fail_in};
    if (!pdh_monitored_out) begin
      raw_fail[F_PDH_LAST:F_PPI_LOS] = '0;
    end
    if (!ts_monitored_out) begin
      raw_fail[F_TS_LAST:F_TS_FIRST] = '0;
    end
  end

  // Sampled once a second; must persist to declare or clear
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fail_q <= '0;
      for (int i = 0; i < NFAIL; i++) begin
        persist_q[i] <= '0;
      end
    end else if (ce_in && sec_pulse) begin
      for (int i = 0; i < NFAIL; i++) begin
        if (raw_fail[i] == fail_q[i]) begin
          persist_q[i] <= '0;
        end else if (persist_q[i] + 4'h1 >=
                     (fail_q[i] ? CLR_SECS : SET_SECS)) begin
          fail_q[i] <= raw_fail[i];
          persist_q[i] <= '0;
        end else begin
          persist_q[i] <= persist_q[i] + 4'h1;
        end
      end
    end
  end

  // --------------------------------------------------------------
  // Performance events and packet rate
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sec.sec_valid <= 1'b0;
      sec.period_end <= 1'b0;
      sec.nebc <= '0;
      sec.febc <= '0;
      sec.nds <= 1'b0;
      sec.fds <= 1'b0;
    end else if (ce_in) begin
      sec.sec_valid <= sec_pulse && pdh_monitored_out;
      sec.period_end <= quarter_end;
      sec.nebc <= near_errored_block_count_in;
      sec.febc <= far_errored_block_count_in;
      sec.nds <= near_defect_second_in;
      sec.fds <= far_defect_second_in;
    end
  end

  mps_perf_event #(
    .SES_THRESH(SES_THRESH)
  ) u_perf (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .sec(sec.perf)
  );

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pkt_cnt_q <= '0;
      pkt_rate_q <= '0;
      fail_time_q <= '0;
      period_time_q <= '0;
    end else if (ce_in) begin
      if (sec_pulse) begin
        pkt_rate_q <= pkt_cnt_q;
        pkt_cnt_q <= {31'h0, packet_pass_in};
      end else if (packet_pass_in) begin
        pkt_cnt_q <= pkt_cnt_q + 32'h1;
      end
      if (sec_pulse && (raw_fail != fail_q)) begin
        fail_time_q <= time_q;
      end
      if (quarter_end) begin
        period_time_q <= time_q;
      end
    end
  end

  // --------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------
  always_comb begin
    irq_set = '0;
    irq_set[NFAIL-1:0] = sec_pulse ? (raw_fail & ~fail_q) : '0;
    irq_set[IRQ_PERIOD_BIT] = quarter_end;
    irq_set[IRQ_DAY_BIT] = day_end;
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_stat_q <= '0;
      irq_out <= 1'b0;
    end else if (ce_in) begin
      if (do_write && aw_addr_q == IRQ_STAT_ADDR) begin
        irq_stat_q <= (irq_stat_q & ~wd[IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat_q <= irq_stat_q | irq_set;
      end
      irq_out <= |(irq_stat_q & irq_mask_q);
    end
  end

  // --------------------------------------------------------------
  // AXI4-Lite write side and configuration
  // --------------------------------------------------------------
  assign do_write = aw_have_q && w_have_q && wr_state_q == WR_IDLE;
  assign wd = merge(32'h0, w_data_q, w_strb_q);

  always_comb begin
    case (aw_addr_q)
      SUP_PPI_ADDR, SUP_PPT_ADDR, SUP_PATH_MULTIPLEX_ENTITY_ADDR, SUP_TSI_ADDR,
      SUP_SCA_ADDR, SUP_VPE_ADDR, MUX_CFG_ADDR, VPI_ADDR,
      PKT_FMT_ADDR, IRQ_STAT_ADDR, IRQ_MASK_ADDR, TIME_ADDR: begin
        wr_hit = 1'b1;
      end
      default: begin
        wr_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_state_q <= WR_IDLE;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce_in) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      case (wr_state_q)
        WR_IDLE: begin
          if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            wr_state_q <= WR_RESP;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            wr_state_q <= WR_IDLE;
          end
        end
        default: begin
          wr_state_q <= WR_IDLE;
        end
      endcase
    end
  end

  // Set items only; nothing here is pushed back by the far side
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pdh_monitored_out <= SUP_RST;
      ts_monitored_out <= SUP_RST;
      cell_discard_out <= DISCARD_RST;
      hec_correct_out <= HEC_RST;
      vpi_out <= '0;
      pkt_format_204_out <= FMT204_RST;
      irq_mask_q <= '0;
    end else if (ce_in && do_write && w_strb_q[0]) begin
      case (aw_addr_q)
        SUP_PPI_ADDR, SUP_PPT_ADDR, SUP_PATH_MULTIPLEX_ENTITY_ADDR: begin
          pdh_monitored_out <= w_data_q[0];
        end
        SUP_TSI_ADDR, SUP_SCA_ADDR, SUP_VPE_ADDR: begin
          ts_monitored_out <= w_data_q[0];
        end
        MUX_CFG_ADDR: begin
          cell_discard_out <= w_data_q[MUX_DISCARD_BIT];
          hec_correct_out <= w_data_q[MUX_HEC_BIT];
        end
        PKT_FMT_ADDR: begin
          pkt_format_204_out <= w_data_q[0];
        end
        default: begin
        end
      endcase
      if (aw_addr_q == VPI_ADDR) begin
        vpi_out <= VPI_W'(merge(32'(vpi_out), w_data_q, w_strb_q));
      end
      if (aw_addr_q == IRQ_MASK_ADDR) begin
        irq_mask_q <= IRQ_W'(merge(32'(irq_mask_q), w_data_q, w_strb_q));
      end
    end else if (ce_in && do_write) begin
      if (aw_addr_q == VPI_ADDR) begin
        vpi_out <= VPI_W'(merge(32'(vpi_out), w_data_q, w_strb_q));
      end
      if (aw_addr_q == IRQ_MASK_ADDR) begin
        irq_mask_q <= IRQ_W'(merge(32'(irq_mask_q), w_data_q, w_strb_q));
      end
    end
  end

  // --------------------------------------------------------------
  // AXI4-Lite read side
  // --------------------------------------------------------------
  assign cur_idx = word_idx(s_axi_araddr, CUR_BASE_ADDR);
  assign rec_idx = word_idx(s_axi_araddr, REC_BASE_ADDR);

  // Status is produced only when the manager asks for it
  always_comb begin
    rd_hit = 1'b1;
    rd_data = '0;
    case (s_axi_araddr)
      SUP_PPI_ADDR: rd_data[0] = pdh_monitored_out;
      SUP_TSI_ADDR: rd_data[0] = ts_monitored_out;
      SUP_PPT_ADDR, SUP_PATH_MULTIPLEX_ENTITY_ADDR, SUP_SCA_ADDR, SUP_VPE_ADDR: begin
        rd_data = '0;
      end
      MUX_CFG_ADDR: begin
        rd_data[MUX_DISCARD_BIT] = cell_discard_out;
        rd_data[MUX_HEC_BIT] = hec_correct_out;
      end
      VPI_ADDR: rd_data = 32'(vpi_out);
      PKT_FMT_ADDR: rd_data[0] = pkt_format_204_out;
      PKT_RATE_ADDR: rd_data = pkt_rate_q;
      FAIL_ADDR: rd_data = 32'(fail_q);
      IRQ_STAT_ADDR: rd_data = 32'(irq_stat_q);
      IRQ_MASK_ADDR: rd_data = 32'(irq_mask_q);
      TIME_ADDR: rd_data = time_q;
      FAIL_TIME_ADDR: rd_data = fail_time_q;
      PERIOD_TIME_ADDR: rd_data = period_time_q;
      default: begin
        if (s_axi_araddr[1:0] == 2'h0 && s_axi_araddr >= CUR_BASE_ADDR &&
            s_axi_araddr < REC_BASE_ADDR) begin
          rd_data = 32'(sec.cur[cur_idx]);
        end else if (s_axi_araddr[1:0] == 2'h0 &&
                     s_axi_araddr >= REC_BASE_ADDR &&
                     s_axi_araddr < REC_BASE_ADDR + 8'(4 * NEV)) begin
          rd_data = 32'(sec.rec[rec_idx]);
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce_in) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // mps_top
`default_nettype wire

// ---- testbench/mps_chk.sv ----
// Purpose: port-level checks for the supervision block
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to mps_top from tb_top
`timescale 1ns/10ps
`default_nettype none
module mps_chk
  import mps_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Bus
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic s_axi_wready, s_axi_bvalid, s_axi_bready,
  input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp, s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  // Provisioning
  input wire logic pdh_monitored_out, ts_monitored_out, pkt_format_204_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence aw_w_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce_in;
  endsequence
  b_answer_a: assert property (aw_w_take |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("aw taken during b");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready && ce_in
    |=> s_axi_rvalid) else $error("read answer late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
  r_request_a: assert property ($rose(s_axi_rvalid)
    |-> $past(s_axi_arvalid)) else $error("unrequested read data");
  set_source_a: assert property (
    !$stable({pdh_monitored_out, ts_monitored_out, pkt_format_204_out})
    |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2)
      || $past(s_axi_wvalid, 3)) else $error("setting moved unwritten");
  err_zero_a: assert property (
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
endmodule // mps_chk
`default_nettype wire

// ---- testbench/mps_far_model.sv ----
// Purpose: basic transmission functions behind the management points
// Assumes: one second shortened to TICK_CYC clock cycles
// Notes: primitives held steady across every second
`timescale 1ns/10ps
`default_nettype none
module mps_far_model #(
  parameter int TICK_CYC = 64
) (
  // Clock, reset, test control
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [13:0] fail_req_in,
  // Towards the equipment manager
  output logic tick_out,
  output logic pkt_out,
  output logic [13:0] fail_out,
  output logic [15:0] nebc_out,
  output logic [15:0] febc_out,
  output logic nds_out,
  output logic fds_out
);
  int cnt_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 0;
    end else begin
      cnt_q <= (cnt_q == TICK_CYC - 1) ? 0 : cnt_q + 1;
    end
  end
  // Half-second high phase clears the synchroniser minimum
  assign tick_out = (cnt_q >= TICK_CYC / 2);
  assign pkt_out = (cnt_q % 8 == 0);
  assign fail_out = fail_req_in;
  assign nebc_out = 16'h0002;
  assign febc_out = 16'h0000;
  assign nds_out = 1'b0;
  assign fds_out = 1'b0;
endmodule // mps_far_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Purpose: self-checking bench for the supervision block
// Assumes: second, quarter and day shortened for simulation
// Notes: master holds each request until its handshake
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import mps_pkg::*;
  logic core_clk_in = 1'b0, rst_n_in = 1'b0, ce_in = 1'b1;
  logic [13:0] fail_req = 14'h0, fl;
  logic tk, pk, nds, fds;
  logic [15:0] nebc, febc;
  logic pdh_monitored_out, ts_monitored_out, cell_discard_out;
  logic hec_correct_out, pkt_format_204_out, irq_out;
  logic [11:0] vpi_out;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  logic [7:0] ra [8] = '{8'h0, 8'hc, 8'h18, 8'h1c, 8'h20, 8'h8, 8'h14, 8'h28};
  logic [1:0] re [8] = '{2'h1, 2'h1, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
  logic [7:0] wa [8] = '{8'h4, 8'h8, 8'h10, 8'h14, 8'h18, 8'h18, 8'h1c, 8'h20};
  logic [7:0] ca [8] = '{8'h0, 8'h0, 8'hc, 8'hc, 8'h18, 8'h18, 8'h1c, 8'h20};
  logic [11:0] wd [8] = '{12'h0, 12'h1, 12'h0, 12'h1, 12'h2, 12'h1, 12'hfff,
                          12'h1};
  logic [3:0] pe [4] = '{4'h5, 4'h0, 4'ha, 4'h0};
  always #12.5 core_clk_in = ~core_clk_in;
  mps_far_model u_far (.clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .fail_req_in(fail_req), .tick_out(tk), .pkt_out(pk), .fail_out(fl),
    .nebc_out(nebc), .febc_out(febc), .nds_out(nds), .fds_out(fds));
  mps_top #(.QUARTER_TICKS(5), .DAY_TICKS(12)) dut (.*, .tick_1s_in(tk),
    .signal_absent_fail_in(fl[0]), .alarm_indication_fail_in(fl[1]),
    .frame_loss_fail_in(fl[2]), .remote_alarm_fail_in(fl[3]),
    .remote_error_fail_in(fl[4]), .remote_defect_fail_in(fl[5]),
    .cell_delineation_loss_in(fl[6]), .status_fail_in(fl[7]),
    .sn_indication_fail_in(fl[8]), .lost_mpeg_cell_fail_in(fl[9]),
    .ts_signal_absent_fail_in(fl[10]), .ts_input_length_fail_in(fl[11]),
    .ts_output_length_fail_in(fl[12]), .hw_transfer_fail_in(fl[13]),
    .near_errored_block_count_in(nebc), .far_errored_block_count_in(febc),
    .near_defect_second_in(nds), .far_defect_second_in(fds),
    .packet_pass_in(pk));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge core_clk_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk_in);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk(s_axi_rdata, e);
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Waits whole seconds, then lets recognition land
  task automatic sec(input int n);
    repeat (n) @(posedge tk);
    repeat (8) @(posedge core_clk_in);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    repeat (10) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    foreach (ra[i]) rc(ra[i], {30'h0, re[i]});
    chk({pdh_monitored_out, ts_monitored_out, cell_discard_out,
      hec_correct_out, pkt_format_204_out, vpi_out}, 32'h1e000);
    $display("reset test done");
    foreach (wa[i]) begin
      wr(wa[i], {20'h0, wd[i]}, rs);
      rc(ca[i], {20'h0, wd[i]});
    end
    chk({pdh_monitored_out, ts_monitored_out, cell_discard_out,
      hec_correct_out, pkt_format_204_out, vpi_out}, 32'h1dfff);
    wr(8'hfc, 32'h1, rs);
    chk(rs, RESP_SLVERR);
    rc(8'hfc, 32'h0);
    chk(rs, RESP_SLVERR);
    $display("config test done");
    sec(2);
    rc(8'h24, 32'h8);
    wr(8'h30, 32'h2000, rs);
    fail_req <= 14'h3fff;
    sec(2);
    rc(8'h28, 32'h0);
    sec(4);
    rc(8'h28, 32'h3fff);
    chk(irq_out, 1'b1);
    wr(8'h2c, 32'hffff, rs);
    repeat (3) @(posedge core_clk_in);
    chk(irq_out, 1'b0);
    fail_req <= 14'h0;
    sec(8);
    rc(8'h28, 32'h3fff);
    sec(4);
    rc(8'h28, 32'h0);
    $display("fault test done");
    wr(8'h34, 32'h100, rs);
    sec(3);
    rc(8'h34, 32'h103);
    sec(4);
    // First period still holds seconds from before the restart
    wr(8'h2c, 32'hffff, rs);
    sec(3);
    foreach (pe[i]) rc(8'h58 + 8'(4 * i), {28'h0, pe[i]});
    rc(8'h2c, 32'h4000);
    $display("period test done");
    results();
  end
endmodule // tb_top
bind mps_top mps_chk u_chk (.*);
`default_nettype wire
